// ==== common/stack_call_pkg.sv ====
`default_nettype none
package stack_call_pkg;
  // ----------------------------------------
  // Widths and encodings
  // ----------------------------------------
  localparam int unsigned PC_W    = 21;
  localparam int unsigned OP_W    = 16;
  localparam int unsigned OFS_W   = 11;
  localparam int unsigned DEPTH   = 31;
  localparam int unsigned PTR_W   = 5;

  localparam logic [OP_W-1:0] OP_PUSH_NEXT  = 16'h0005;
  localparam logic [OP_W-1:0] OP_SOFT_RESET = 16'h00FF;
  localparam logic [4:0]      OP_RELATIVE_SUBROUTINE_CALL_OP_HI   = 5'h1B;
  localparam int unsigned     RELATIVE_SUBROUTINE_CALL_OP_HI_LSB  = 11;
  localparam logic [PC_W-1:0] PC_STEP       = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET      = 21'h000000;
  localparam logic [PTR_W-1:0] PTR_RESET    = 5'h00;

  typedef enum logic [1:0] {
    ST_EXEC,
    ST_FLUSH
  } exec_state_t;

  // Instruction slot offered by fetch
  typedef struct packed {
    logic            valid;
    logic [OP_W-1:0] opcode;
    logic [PC_W-1:0] pc;
  } instr_t;

  // Write port of the software-visible top entry
  typedef struct packed {
    logic            we;
    logic [PC_W-1:0] data;
  } top_wr_t;
endpackage
`default_nettype wire

// ==== rtl/return_stack_mem.sv ====
`default_nettype none
module return_stack_mem
  import stack_call_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              we_i,
  input  wire logic [PTR_W-1:0]  waddr_i,
  input  wire logic [PC_W-1:0]   wdata_i,
  input  wire logic [PTR_W-1:0]  raddr_i,
  output logic      [PC_W-1:0]   rdata_o
);
  logic [PC_W-1:0] mem [DEPTH];

  // Lower levels only; no reset needed for storage
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule
`default_nettype wire

// ==== rtl/stack_call_exec.sv ====
// Functional notes
// - Opcode 0x0005 pushes pc+2 as new top entry in one cycle.
// - A software-written top entry is pushed down intact; a same-cycle push or call, or a stall or clear cycle, drops it.
// - Upper bits 11011 decode a relative call with 11-bit offset.
// - Relative call saves pc+2 on the stack in the same cycle it changes pc.
// - Offset is signed two's complement, doubled, range -1024..1023.
// - Call target is pc+2 plus twice the signed offset.
// - Relative call takes two instruction cycles.
// - Opcode 0x00FF resets everything an external master clear resets.
// - Software reset is single word, single cycle, without the pin.
`default_nettype none
module stack_call_exec
  import stack_call_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              arst_n_i,
  input  wire instr_t            instr_i,
  input  wire top_wr_t           top_wr_i,
  output logic      [PC_W-1:0]   program_counter_o,
  output logic      [PC_W-1:0]   stack_top_entry_o,
  output logic      [PTR_W-1:0]  stack_depth_o,
  output logic                   pc_load_o,
  output logic                   stall_o,
  output logic                   master_clear_o,
  output logic                   status_hold_o
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic is_relative_subroutine_call_op(input logic [OP_W-1:0] op);
    return op[OP_W-1:RELATIVE_SUBROUTINE_CALL_OP_HI_LSB] == OP_RELATIVE_SUBROUTINE_CALL_OP_HI;
  endfunction

  function automatic logic [PC_W-1:0] call_target(input logic [PC_W-1:0] pc,
                                                  input logic [OFS_W-1:0] ofs);
    logic [PC_W-1:0] ext;
    ext = {{(PC_W-OFS_W){ofs[OFS_W-1]}}, ofs};
    return pc + PC_STEP + (ext << 1);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    exec_state_t      st;
    logic [PC_W-1:0]  pc;
    logic [PC_W-1:0]  top;
    logic [PTR_W-1:0] depth;
    logic             pc_load;
    logic             master_clear;
    logic             stall;
    logic             hold;
  } regs_t;

  // Status hold is a flop so that every output leaves a register
  localparam regs_t REGS_RESET = '{st: ST_EXEC, pc: PC_RESET, top: PC_RESET,
                                   depth: PTR_RESET, pc_load: 1'h0, master_clear: 1'h0,
                                   stall: 1'h0, hold: 1'h1};

  regs_t            r;
  regs_t            next_r;
  logic             mem_we;
  logic [PC_W-1:0]  mem_rdata;
  logic [PTR_W-1:0] rd_ptr;
  logic             issue_ok;
  logic             op_push;
  logic             op_call;
  logic             op_rst;

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  // Stall and clear cycles drop whatever fetch offers, with no indication
  assign issue_ok = instr_i.valid && r.st == ST_EXEC && !r.master_clear;
  assign op_push  = issue_ok && instr_i.opcode == OP_PUSH_NEXT;
  assign op_call  = issue_ok && is_relative_subroutine_call_op(instr_i.opcode);
  assign op_rst   = issue_ok && instr_i.opcode == OP_SOFT_RESET;

  // ----------------------------------------
  // Return stack below the top entry
  // ----------------------------------------
  // Old top moves down one level on either push
  assign mem_we = op_push || op_call;
  // Level just below the top; only the push-down check reads it
  assign rd_ptr = r.depth - 5'h01;

  return_stack_mem u_mem (
    .clk_sys_i (clk_sys_i),
    .we_i      (mem_we),
    .waddr_i   (r.depth),
    .wdata_i   (r.top),
    .raddr_i   (rd_ptr),
    .rdata_o   (mem_rdata)
  );

  always_comb begin
    next_r         = r;
    next_r.pc_load = 1'b0;
    next_r.master_clear    = 1'b0;
    next_r.stall   = 1'h0;
    unique case (r.st)
      ST_EXEC: begin
        if (top_wr_i.we) begin
          next_r.top = top_wr_i.data;
        end
        if (op_rst) begin
          next_r.master_clear = 1'b1;
        end else if (op_push) begin
          next_r.top   = instr_i.pc + PC_STEP;
          next_r.depth = r.depth + 5'h01;
          next_r.pc    = instr_i.pc + PC_STEP;
        end else if (op_call) begin
          next_r.top     = instr_i.pc + PC_STEP;
          next_r.depth   = r.depth + 5'h01;
          next_r.pc      = call_target(instr_i.pc, instr_i.opcode[OFS_W-1:0]);
          next_r.pc_load = 1'b1;
          next_r.st      = ST_FLUSH;
          next_r.stall   = 1'h1;
        end else if (instr_i.valid) begin
          next_r.pc = instr_i.pc + PC_STEP;
        end
      end
      ST_FLUSH: begin
        next_r.st = ST_EXEC;
      end
      default: begin
        next_r.st = ST_EXEC;
      end
    endcase
  end

  // Soft reset acts like the pin: whole state back to reset values
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      r <= REGS_RESET;
    end else if (r.master_clear) begin
      r <= REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign program_counter_o = r.pc;
  assign stack_top_entry_o = r.top;
  assign stack_depth_o     = r.depth;
  assign pc_load_o         = r.pc_load;
  assign stall_o           = r.stall;
  assign master_clear_o    = r.master_clear;
  // Status flags never written by these ops
  assign status_hold_o     = r.hold;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Push checks
  // ----------------------------------------
  push_top_a: assert property (op_push |=> r.top == $past(instr_i.pc) + PC_STEP)
    else $error("push top wrong");
  push_depth_a: assert property (op_push |=> r.depth == $past(r.depth) + 5'h01)
    else $error("push depth wrong");
  push_one_a: assert property (op_push |=> !stall_o && !pc_load_o)
    else $error("push took more than one cycle");
  push_below_a: assert property (mem_we |-> ##2 mem_rdata == $past(r.top, 2))
    else $error("old top not pushed down");

  // ----------------------------------------
  // Call checks
  // ----------------------------------------
  call_target_a: assert property (op_call && !r.master_clear |=> r.pc ==
      call_target($past(instr_i.pc), $past(instr_i.opcode[OFS_W-1:0])))
    else $error("call target wrong");
  call_ret_a: assert property (op_call |=> r.top == $past(instr_i.pc) + PC_STEP)
    else $error("call return wrong");
  call_depth_a: assert property (op_call |=> r.depth == $past(r.depth) + 5'h01)
    else $error("call depth wrong");
  call_load_a: assert property (op_call |=> pc_load_o ##1 !pc_load_o)
    else $error("pc load not one pulse");
  sequence call_seq; op_call && !r.master_clear; endsequence
  sequence flush_seq; stall_o ##1 !stall_o; endsequence
  call_two_a: assert property (call_seq |=> flush_seq)
    else $error("call not two cycles");
  flush_idle_a: assert property (stall_o |=> $stable(r.depth) && !r.master_clear)
    else $error("flush not idle");
  flush_pc_a: assert property (stall_o |=> $stable(r.pc) && $stable(r.top))
    else $error("flush changed pc or top");
  stall_src_a: assert property ($rose(stall_o) |-> $past(op_call))
    else $error("stall without a call");

  // ----------------------------------------
  // Reset and top write checks
  // ----------------------------------------
  sequence clear_seq;
    master_clear_o ##1 !master_clear_o && r.depth == PTR_RESET && r.pc == PC_RESET
      && r.top == PC_RESET;
  endsequence
  soft_rst_a: assert property (op_rst |=> clear_seq)
    else $error("soft reset failed");
  rst_one_a: assert property (op_rst |=> !stall_o && !pc_load_o)
    else $error("soft reset not single cycle");
  top_keep_a: assert property (top_wr_i.we && r.st == ST_EXEC && !instr_i.valid && !r.master_clear
      |=> r.top == $past(top_wr_i.data))
    else $error("top write lost");
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
`default_nettype none
module tb
  import stack_call_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Stimulus and design
  // ----------------------------------------
  logic             clk_sys_i = 1'b0;
  logic             arst_n_i  = 1'b0;
  instr_t           instr     = '0;
  top_wr_t          top_wr    = '0;
  logic [PC_W-1:0]  pc_q;
  logic [PC_W-1:0]  top_q;
  logic [PTR_W-1:0] depth_q;
  logic             load_q;
  logic             stall_q;
  logic             master_clear_q;
  logic             hold_q;
  int               bad_count = 0;
  int               total_checks = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  stack_call_exec uut (
    .clk_sys_i         (clk_sys_i),
    .arst_n_i          (arst_n_i),
    .instr_i           (instr),
    .top_wr_i          (top_wr),
    .program_counter_o (pc_q),
    .stack_top_entry_o (top_q),
    .stack_depth_o     (depth_q),
    .pc_load_o         (load_q),
    .stall_o           (stall_q),
    .master_clear_o    (master_clear_q),
    .status_hold_o     (hold_q)
  );
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Outputs are judged at the falling edge, after the taking edge settled
  task automatic issue(input logic [OP_W-1:0] op, input logic [PC_W-1:0] pc, input top_wr_t wr);
    @(posedge clk_sys_i);
    instr  <= '{1'b1, op, pc};
    top_wr <= wr;
    @(posedge clk_sys_i);
    instr  <= '0;
    top_wr <= '0;
    @(negedge clk_sys_i);
  endtask
  task automatic push_test();
    issue(OP_PUSH_NEXT, 21'h000124, '0);
    chk("pc", pc_q, 21'h000126);
    chk("top", top_q, 21'h000126);
    chk("depth", PC_W'(depth_q), 21'h000001);
    chk("hold", PC_W'(hold_q), 21'h000001);
    $display("push test done");
  endtask
  task automatic top_test();
    issue(16'h0000, 21'h000010, '{1'b1, 21'h00345A});
    chk("top written", top_q, 21'h00345A);
    issue(OP_PUSH_NEXT, 21'h000124, '0);
    chk("top", top_q, 21'h000126);
    chk("depth", PC_W'(depth_q), 21'h000002);
    issue(OP_PUSH_NEXT, 21'h000200, '{1'b1, 21'h01FFFF});
    chk("push wins", top_q, 21'h000202);
    chk("depth", PC_W'(depth_q), 21'h000003);
    $display("top entry test done");
  endtask
  // A push offered during the stall cycle must be dropped
  task automatic call_test(input logic [PC_W-1:0] pc, input logic [OFS_W-1:0] n);
    logic [PC_W-1:0]  exp;
    logic [PTR_W-1:0] d;
    d   = depth_q + 5'h01;
    exp = pc + PC_STEP + {{9{n[10]}}, n, 1'b0};
    @(posedge clk_sys_i);
    instr <= '{1'b1, {OP_RELATIVE_SUBROUTINE_CALL_OP_HI, n}, pc};
    @(posedge clk_sys_i);
    instr <= '{1'b1, OP_PUSH_NEXT, exp};
    @(negedge clk_sys_i);
    chk("call pc", pc_q, exp);
    chk("call top", top_q, pc + PC_STEP);
    chk("call depth", PC_W'(depth_q), PC_W'(d));
    chk("pc load", PC_W'(load_q), 21'h000001);
    chk("stall", PC_W'(stall_q), 21'h000001);
    @(posedge clk_sys_i);
    instr <= '0;
    @(negedge clk_sys_i);
    chk("stall end", PC_W'(stall_q), 21'h000000);
    chk("pc load end", PC_W'(load_q), 21'h000000);
    chk("dead depth", PC_W'(depth_q), PC_W'(d));
    chk("dead pc", pc_q, exp);
    chk("hold", PC_W'(hold_q), 21'h000001);
    $display("call test done");
  endtask
  task automatic reset_test();
    issue(OP_SOFT_RESET, 21'h000300, '0);
    chk("clear pulse", PC_W'(master_clear_q), 21'h000001);
    @(negedge clk_sys_i);
    chk("clear end", PC_W'(master_clear_q), 21'h000000);
    chk("pc", pc_q, PC_RESET);
    chk("top", top_q, 21'h000000);
    chk("depth", PC_W'(depth_q), PC_W'(PTR_RESET));
    $display("soft reset test done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    push_test();
    top_test();
    call_test(21'h001000, 11'h400);
    call_test(21'h001000, 11'h3FF);
    call_test(21'h001000, 11'h000);
    call_test(21'h001000, 11'h7FF);
    reset_test();
    results();
  end
  // Guard against a hang
  initial begin
    #200000;
    bad_count++;
    results();
  end
endmodule
`default_nettype wire
